// file: tlat_defines.vh
`ifndef TLAT_DEFINES_VH
`define TLAT_DEFINES_VH
`define TLAT_VPN_W      51
`define TLAT_PPN_W      34
`define TLAT_CTX_W      13
`define TLAT_PA_W       47
`define TLAT_A_CTRL     8'h00
`define TLAT_A_CTX      8'h04
`define TLAT_A_TBASE    8'h08
`define TLAT_A_EXT_I    8'h0c
`define TLAT_A_EXT_D    8'h10
`define TLAT_A_TAG      8'h14
`define TLAT_A_DIN_I    8'h18
`define TLAT_A_DIN_D    8'h1c
`define TLAT_A_STATUS   8'h20
`define TLAT_A_MASK     8'h24
`define TLAT_A_PTR_I    8'h28
`define TLAT_A_PTR_D    8'h2c
`define TLAT_CTRL_LEGACY 0
`define TLAT_CTRL_SPLIT  1
`define TLAT_TE_VALID   63
`define TLAT_TE_SZ_HI   62
`define TLAT_TE_SZ_LO   61
`define TLAT_TE_LOCK    60
`define TLAT_TE_PPN_HI  46
`define TLAT_TE_PPN_LO  13
`define TLAT_ST_MHIT_I  0
`define TLAT_ST_MHIT_D  1
`define TLAT_ST_MISS_I  2
`define TLAT_ST_MISS_D  3
`define TLAT_RST_CTRL   64'h0000000000000000
`define TLAT_RST_MASK   4'h0
`define TLAT_TBL_MIN    9
`define TLAT_L1_N       4
`define TLAT_FA_N       8
`define TLAT_SA_SETS    16
`endif

// file: tlat_fa_array.v
`timescale 1ns/10ps
`include "tlat_defines.vh"
module tlat_fa_array #(
    parameter N  = 4,
    parameter IW = 2
) (
    input  wire                   clk,
    input  wire                   resetn,
    input  wire                   flush,
    input  wire                   wr_en,
    input  wire [IW-1:0]          wr_idx,
    input  wire [`TLAT_VPN_W-1:0] wr_vpn,
    input  wire [`TLAT_CTX_W-1:0] wr_ctx,
    input  wire [1:0]             wr_size,
    input  wire [`TLAT_PPN_W-1:0] wr_ppn,
    input  wire                   wr_lock,
    input  wire [`TLAT_VPN_W-1:0] lk_vpn,
    input  wire [`TLAT_CTX_W-1:0] lk_ctx,
    output reg  [N-1:0]           hit_vec,
    output reg  [`TLAT_PPN_W-1:0] hit_ppn,
    output reg  [1:0]             hit_size,
    output reg  [N-1:0]           valid_vec,
    output reg  [N-1:0]           lock_vec
);
    reg [`TLAT_VPN_W-1:0] vpn  [0:N-1];
    reg [`TLAT_CTX_W-1:0] ctx  [0:N-1];
    reg [`TLAT_PPN_W-1:0] ppn  [0:N-1];
    reg [1:0]             size [0:N-1];
    integer k;

    // larger pages ignore three more page-number bits per size step
    function [`TLAT_VPN_W-1:0] smask;
        input [1:0] s;
        smask = {`TLAT_VPN_W{1'b1}} << (3 * s);
    endfunction

    // every entry compared at once; several hits are or-ed, caller judges
    always @*
    begin
        hit_ppn = {`TLAT_PPN_W{1'b0}};
        hit_size = 2'h0;
        for (k = 0; k < N; k = k + 1)
        begin
            hit_vec[k] = valid_vec[k] && (ctx[k] == lk_ctx) &&
                         (((vpn[k] ^ lk_vpn) & smask(size[k])) == {`TLAT_VPN_W{1'b0}});
            if (hit_vec[k])
            begin
                hit_ppn = hit_ppn | ppn[k];
                hit_size = hit_size | size[k];
            end
        end
    end

    // valid and lock under reset; payload needs none
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            valid_vec <= {N{1'b0}};
            lock_vec <= {N{1'b0}};
        end
        else
        begin
            if (flush)
                valid_vec <= lock_vec & valid_vec;
            if (wr_en)
            begin
                valid_vec[wr_idx] <= 1'b1;
                lock_vec[wr_idx] <= wr_lock;
            end
        end
    end

    always @(posedge clk)
    begin
        if (wr_en)
        begin
            vpn[wr_idx] <= wr_vpn;
            ctx[wr_idx] <= wr_ctx;
            ppn[wr_idx] <= wr_ppn;
            size[wr_idx] <= wr_size;
        end
    end
endmodule

// file: tlat_top.v
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
`include "tlat_defines.vh"
module tlat_top (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire [7:0]  reg_addr,
    input  wire [63:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [63:0] reg_rdata,
    output reg         irq,
    input  wire        i_req,
    input  wire [63:0] i_va,
    output wire        i_ready,
    output wire        i_done,
    output wire        i_hit,
    output wire        i_mhit,
    output wire [46:0] i_pa,
    output wire [40:0] i_line_tag,
    input  wire        d_req,
    input  wire [63:0] d_va,
    output wire        d_ready,
    output wire        d_done,
    output wire        d_hit,
    output wire        d_mhit,
    output wire [46:0] d_pa,
    output wire [40:0] d_line_tag
);
    localparam ST_IDLE = 3'b001;
    localparam ST_L1   = 3'b010;
    localparam ST_L2   = 3'b100;

    reg [63:0]             ctrl, tbase, ext_i, ext_d, tag_acc;
    reg [`TLAT_CTX_W-1:0]  ctx_id;
    reg [3:0]              status, mask;
    wire [3:0]             ev;
    wire [127:0]           ptr_w, va_w;
    wire [1:0]             rdy_w, done_w, hit_w, mh_w, req_w, din_w;
    wire [93:0]            pa_w;
    wire [81:0]            lt_w;
    wire                   legacy;

    assign req_w = {d_req, i_req};
    assign va_w = {d_va, i_va};
    assign din_w = {reg_wr && (reg_addr == `TLAT_A_DIN_D),
                    reg_wr && (reg_addr == `TLAT_A_DIN_I)};
    assign legacy = ctrl[`TLAT_CTRL_LEGACY];

    // outputs below all come straight from per-side flops
    assign {d_ready, i_ready} = rdy_w;
    assign {d_done, i_done} = done_w;
    assign {d_hit, i_hit} = hit_w;
    assign {d_mhit, i_mhit} = mh_w;
    assign {d_pa, i_pa} = pa_w;
    assign {d_line_tag, i_line_tag} = lt_w;

    // physical address: page number above offset, offset widens with size
    function [46:0] make_pa;
        input [33:0] pn;
        input [1:0]  sz;
        input [63:0] va;
        reg   [46:0] off;
        begin
            off = ~({47{1'b1}} << (13 + 3 * sz));
            make_pa = ({pn, 13'h0000} & ~off) | (va[46:0] & off);
        end
    endfunction

    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1)
        begin : g_side
            reg [2:0]             st;
            reg [63:0]            va_q, ptr_q;
            reg [`TLAT_CTX_W-1:0] cx_q;
            reg                   rdy_q, done_q, hit_q, mh_q, mh_ev, ms_ev;
            reg [46:0]            pa_q;
            reg [1:0]             l1_rr, l2_sz, sa_hit;
            reg [2:0]             fa_rr, fa_vic;
            reg [`TLAT_VPN_W-1:0] sa_vpn [0:31];
            reg [`TLAT_CTX_W-1:0] sa_ctx [0:31];
            reg [`TLAT_PPN_W-1:0] sa_ppn [0:31];
            reg [31:0]            sa_val;
            reg [15:0]            sa_lru;
            reg [3:0]             nhit;
            reg [33:0]            l2_ppn;
            integer               j, vi;
            wire [63:0]           wd, base;
            wire [4:0]            ibits;
            wire [3:0]            l1_hv, set_q, set_w;
            wire [33:0]           l1_ppn, fa_ppn;
            wire [1:0]            l1_sz, fa_sz;
            wire [7:0]            fa_hv, fa_val, fa_lk;
            wire [50:0]           vpn_q;
            wire                  to_fa, fill, wr_sa, way;

            assign wd = reg_wdata;
            assign vpn_q = va_q[63:13];
            assign set_q = va_q[16:13];
            assign set_w = tag_acc[16:13];
            // locked or large page goes to the fully associative side
            assign to_fa = wd[`TLAT_TE_LOCK] | (wd[`TLAT_TE_SZ_HI:`TLAT_TE_SZ_LO] != 2'h0);
            assign wr_sa = din_w[s] & wd[`TLAT_TE_VALID] & ~to_fa;
            // single level-2 hit after a micro miss refills the micro buffer
            assign fill = st[2] & (nhit == 4'h1);
            assign way = ~sa_val[{set_w, 1'b0}] ? 1'b0 :
                         ~sa_val[{set_w, 1'b1}] ? 1'b1 : sa_lru[set_w];

            // micro buffer: searched on every reference of this side
            tlat_fa_array #(.N(`TLAT_L1_N), .IW(2)) u_micro (
                .clk       (sys_clk),
                .resetn    (resetn),
                .flush     (din_w[s]),
                .wr_en     (fill),
                .wr_idx    (l1_rr),
                .wr_vpn    (vpn_q),
                .wr_ctx    (cx_q),
                .wr_size   (l2_sz),
                .wr_ppn    (l2_ppn),
                .wr_lock   (1'b0),
                .lk_vpn    (vpn_q),
                .lk_ctx    (cx_q),
                .hit_vec   (l1_hv),
                .hit_ppn   (l1_ppn),
                .hit_size  (l1_sz),
                .valid_vec (),
                .lock_vec  ()
            );

            // level-2 fully associative part, the only home of locked entries
            tlat_fa_array #(.N(`TLAT_FA_N), .IW(3)) u_l2fa (
                .clk       (sys_clk),
                .resetn    (resetn),
                .flush     (1'b0),
                .wr_en     (din_w[s] & wd[`TLAT_TE_VALID] & to_fa),
                .wr_idx    (fa_vic),
                .wr_vpn    (tag_acc[63:13]),
                .wr_ctx    (tag_acc[12:0]),
                .wr_size   (wd[`TLAT_TE_SZ_HI:`TLAT_TE_SZ_LO]),
                .wr_ppn    (wd[`TLAT_TE_PPN_HI:`TLAT_TE_PPN_LO]),
                .wr_lock   (wd[`TLAT_TE_LOCK]),
                .lk_vpn    (vpn_q),
                .lk_ctx    (cx_q),
                .hit_vec   (fa_hv),
                .hit_ppn   (fa_ppn),
                .hit_size  (fa_sz),
                .valid_vec (fa_val),
                .lock_vec  (fa_lk)
            );

            // victim: free slot first, else round robin skipping locked ones
            always @*
            begin
                fa_vic = fa_rr;
                for (vi = 7; vi >= 0; vi = vi - 1)
                    if (!fa_lk[fa_rr + vi[2:0]])
                        fa_vic = fa_rr + vi[2:0];
                for (vi = 7; vi >= 0; vi = vi - 1)
                    if (!fa_val[vi])
                        fa_vic = vi[2:0];
            end

            // set-associative lookup and hit count across both parts
            always @*
            begin
                l2_ppn = fa_ppn;
                l2_sz = fa_sz;
                nhit = 4'h0;
                for (j = 0; j < 2; j = j + 1)
                begin
                    sa_hit[j] = sa_val[{set_q, j[0]}] &&
                                (sa_vpn[{set_q, j[0]}] == vpn_q) &&
                                (sa_ctx[{set_q, j[0]}] == cx_q);
                    if (sa_hit[j])
                        l2_ppn = l2_ppn | sa_ppn[{set_q, j[0]}];
                end
                for (j = 0; j < 8; j = j + 1)
                    nhit = nhit + {3'h0, fa_hv[j]};
                nhit = nhit + {3'h0, sa_hit[0]} + {3'h0, sa_hit[1]};
            end

            // table pointer: base by legacy select, hash from page number and context id
            assign base = legacy ? ((s == 0) ? ext_i : ext_d) : tbase;
            assign ibits = 5'd`TLAT_TBL_MIN + {1'b0, base[3:0]} +
                           {4'h0, ctrl[`TLAT_CTRL_SPLIT]};

            // set-associative store holds 8K pages only and never a lock
            always @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    sa_val <= 32'h00000000;
                    sa_lru <= 16'h0000;
                end
                else if (wr_sa)
                begin
                    sa_val[{set_w, way}] <= 1'b1;
                    sa_lru[set_w] <= ~way;
                end
            end

            always @(posedge sys_clk)
            begin
                if (wr_sa)
                begin
                    sa_vpn[{set_w, way}] <= tag_acc[63:13];
                    sa_ctx[{set_w, way}] <= tag_acc[12:0];
                    sa_ppn[{set_w, way}] <= wd[`TLAT_TE_PPN_HI:`TLAT_TE_PPN_LO];
                end
            end

            // request sequencer: micro lookup, then level-2, then refill
            always @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    st <= ST_IDLE;
                    va_q <= 64'h0000000000000000;
                    cx_q <= 13'h0000;
                    rdy_q <= 1'b0;
                    done_q <= 1'b0;
                    hit_q <= 1'b0;
                    mh_q <= 1'b0;
                    pa_q <= 47'h000000000000;
                    ptr_q <= 64'h0000000000000000;
                    mh_ev <= 1'b0;
                    ms_ev <= 1'b0;
                    l1_rr <= 2'h0;
                    fa_rr <= 3'h0;
                end
                else
                begin
                    done_q <= 1'b0;
                    mh_ev <= 1'b0;
                    ms_ev <= 1'b0;
                    if (din_w[s] & wd[`TLAT_TE_VALID] & to_fa)
                        fa_rr <= fa_vic + 3'h1;
                    case (st)
                        ST_IDLE:
                        begin
                            rdy_q <= 1'b1;
                            if (req_w[s] && rdy_q)
                            begin
                                va_q <= va_w[64*s+63 -: 64];
                                cx_q <= ctx_id;
                                rdy_q <= 1'b0;
                                st <= ST_L1;
                            end
                        end
                        ST_L1:
                        begin
                            // micro hit completes with no multiple-hit check
                            if (l1_hv != 4'h0)
                            begin
                                done_q <= 1'b1;
                                hit_q <= 1'b1;
                                mh_q <= 1'b0;
                                pa_q <= make_pa(l1_ppn, l1_sz, va_q);
                                st <= ST_IDLE;
                            end
                            else
                                st <= ST_L2;
                        end
                        ST_L2:
                        begin
                            if (nhit == 4'h1)
                            begin
                                l1_rr <= l1_rr + 2'h1;
                                st <= ST_L1;
                            end
                            else
                            begin
                                done_q <= 1'b1;
                                hit_q <= 1'b0;
                                mh_q <= (nhit != 4'h0);
                                mh_ev <= (nhit != 4'h0);
                                ms_ev <= (nhit == 4'h0);
                                pa_q <= 47'h000000000000;
                                if (nhit == 4'h0)
                                    ptr_q <= (base & ~64'h0000000000001fff) |
                                             ((({13'h0, vpn_q} ^ {51'h0, cx_q}) &
                                               ~({64{1'b1}} << ibits)) << 4);
                                st <= ST_IDLE;
                            end
                        end
                        default:
                            st <= ST_IDLE;
                    endcase
                end
            end

            assign rdy_w[s] = rdy_q;
            assign done_w[s] = done_q;
            assign hit_w[s] = hit_q;
            assign mh_w[s] = mh_q;
            assign pa_w[47*s+46 -: 47] = pa_q;
            // entries keep no cacheable-virtual flag; aliasing is the caches' job
            assign lt_w[41*s+40 -: 41] = pa_q[46:6];
            assign ptr_w[64*s+63 -: 64] = ptr_q;
            assign ev[s] = mh_ev;
            assign ev[s+2] = ms_ev;
        end
    endgenerate

    // software registers; status set wins over write-one-to-clear
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl <= `TLAT_RST_CTRL;
            ctx_id <= 13'h0000;
            tbase <= 64'h0000000000000000;
            ext_i <= 64'h0000000000000000;
            ext_d <= 64'h0000000000000000;
            tag_acc <= 64'h0000000000000000;
            status <= 4'h0;
            mask <= `TLAT_RST_MASK;
            irq <= 1'b0;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `TLAT_A_CTRL:  ctrl <= {62'h0, reg_wdata[1:0]};
                    `TLAT_A_CTX:   ctx_id <= reg_wdata[12:0];
                    `TLAT_A_TBASE: tbase <= reg_wdata;
                    `TLAT_A_EXT_I: ext_i <= reg_wdata;
                    `TLAT_A_EXT_D: ext_d <= reg_wdata;
                    `TLAT_A_TAG:   tag_acc <= reg_wdata;
                    `TLAT_A_MASK:  mask <= reg_wdata[3:0];
                    default:       ctx_id <= ctx_id;
                endcase
            end
            if (reg_wr && (reg_addr == `TLAT_A_STATUS))
                status <= (status & ~reg_wdata[3:0]) | ev;
            else
                status <= status | ev;
            irq <= |(status & mask);
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 64'h0000000000000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `TLAT_A_CTRL:   reg_rdata <= ctrl;
                `TLAT_A_CTX:    reg_rdata <= {51'h0, ctx_id};
                `TLAT_A_TBASE:  reg_rdata <= tbase;
                `TLAT_A_EXT_I:  reg_rdata <= ext_i;
                `TLAT_A_EXT_D:  reg_rdata <= ext_d;
                `TLAT_A_TAG:    reg_rdata <= tag_acc;
                `TLAT_A_STATUS: reg_rdata <= {60'h0, status};
                `TLAT_A_MASK:   reg_rdata <= {60'h0, mask};
                `TLAT_A_PTR_I:  reg_rdata <= ptr_w[63:0];
                `TLAT_A_PTR_D:  reg_rdata <= ptr_w[127:64];
                default:        reg_rdata <= 64'h0000000000000000;
            endcase
        end
        else
            reg_rdata <= 64'h0000000000000000;
    end
endmodule

// file: tlat_sva.sv
`timescale 1ns/10ps
module tlat_sva (
    input wire        sys_clk,
    input wire        resetn,
    input wire        reg_rd,
    input wire [63:0] reg_rdata,
    input wire        i_req,
    input wire        i_ready,
    input wire        i_done,
    input wire        i_hit,
    input wire        i_mhit,
    input wire [46:0] i_pa,
    input wire [40:0] i_line_tag,
    input wire        d_ready,
    input wire        d_done,
    input wire [46:0] d_pa,
    input wire [40:0] d_line_tag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // a request counts only when the side is idle
    sequence s_itake; i_req && i_ready; endsequence
    property p_ilat; s_itake |-> ##[2:4] i_done; endproperty
    a_ilat: assert property (p_ilat) else $error("instr result late");
    property p_imicro; s_itake ##2 i_done |-> i_hit && !i_mhit; endproperty
    a_imicro: assert property (p_imicro) else $error("fast result not a clean hit");
    property p_ibusy; s_itake |=> !i_ready [*2]; endproperty
    a_ibusy: assert property (p_ibusy) else $error("ready during lookup");
    property p_tag; i_line_tag == i_pa[46:6] && d_line_tag == d_pa[46:6]; endproperty
    a_tag: assert property (p_tag) else $error("line tag not pa bits");
    property p_imhit; i_done && i_mhit |-> !i_hit; endproperty
    a_imhit: assert property (p_imhit) else $error("multi hit reported as hit");
    property p_imiss; i_done && !i_hit |-> i_pa == 47'h0; endproperty
    a_imiss: assert property (p_imiss) else $error("pa not cleared on miss");
    property p_rd; !reg_rd |=> reg_rdata == 64'h0; endproperty
    a_rd: assert property (p_rd) else $error("read data outside read slot");
    property p_dready; d_done |=> d_ready; endproperty
    a_dready: assert property (p_dready) else $error("data side not idle after done");
endmodule
bind tlat_top tlat_sva u_sva (.*);

// file: tlat_core_model.sv
`timescale 1ns/10ps
module tlat_core_model (
    input  wire         clk,
    input  wire         ready,
    input  wire         done,
    input  wire         hit,
    input  wire         mhit,
    input  wire  [46:0] pa,
    output logic        req,
    output logic [63:0] va
);
    logic [48:0] got;
    int          lat;
    initial
    begin
        req = 1'b0;
        va  = 64'h0;
    end
    // hold until taken, then park the address on its inverse so stale values never match
    task automatic xlate(input logic [63:0] a);
        int n;
        n = 0;
        req <= 1'b1;
        va  <= a;
        do @(posedge clk); while (ready !== 1'b1 && ++n < 99);
        req <= 1'b0;
        va  <= ~a;
        // count every edge up to and including the one that sees done
        lat = 0;
        do
        begin
            @(posedge clk);
            lat++;
        end
        while (done !== 1'b1 && lat < 20);
        got = {hit, mhit, pa};
    endtask
endmodule

// file: tb.sv
`timescale 1ns/10ps
`include "tlat_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    typedef struct {logic d; logic [63:0] va; logic [48:0] r; int lat;} tlat_row_t;
    logic        sys_clk, resetn, reg_wr, reg_rd;
    logic [7:0]  reg_addr;
    logic [63:0] reg_wdata, b, m, v;
    logic [48:0] g;
    wire  [63:0] reg_rdata, i_va, d_va;
    wire  [46:0] i_pa, d_pa;
    wire         irq, i_req, i_ready, i_done, i_hit, i_mhit;
    wire         d_req, d_ready, d_done, d_hit, d_mhit;
    int          check_count, miscompares, cyc, l;
    // {hit, mhit, pa} and cycles from taken edge to done
    tlat_row_t rows [6] = '{
        '{1'b1, 64'h0000_0abc_de00_0123, {2'b10, 47'h1234_5678_0123}, 4},
        '{1'b1, 64'h0000_0abc_de00_0456, {2'b10, 47'h1234_5678_0456}, 2},
        '{1'b0, 64'h0000_0000_4001_1abc, {2'b10, 47'h0222_3333_1abc}, 4},
        '{1'b0, 64'h0000_0000_4001_0008, {2'b10, 47'h0222_3333_0008}, 2},
        '{1'b0, 64'h0000_0000_7000_2010, {2'b01, 47'h0}, 3},
        '{1'b1, 64'h0000_0000_0940_0000, {2'b00, 47'h0}, 3}};
    tlat_top dut (.*, .i_line_tag(), .d_line_tag());
    tlat_core_model u_im (.clk(sys_clk), .ready(i_ready), .done(i_done), .hit(i_hit),
        .mhit(i_mhit), .pa(i_pa), .req(i_req), .va(i_va));
    tlat_core_model u_dm (.clk(sys_clk), .ready(d_ready), .done(d_done), .hit(d_hit),
        .mhit(d_mhit), .pa(d_pa), .req(d_req), .va(d_va));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // strobe then one idle cycle, so back-to-back calls never drive a strobe twice in a step
    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [63:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(posedge sys_clk);
        `CHK("reg", e, reg_rdata)
    endtask
    initial
    begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {check_count, miscompares, cyc} = '0;
        repeat (12) @(posedge sys_clk);
        `CHK("idle", 3'b000, {i_ready, d_ready, irq})
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(`TLAT_A_CTRL, 64'h0);
        rd(`TLAT_A_MASK, 64'h0);
        rd(8'h30, 64'h0);
        wr(`TLAT_A_CTX, 64'h5);
        wr(`TLAT_A_TBASE, 64'h0000_0040_0000_0000);
        wr(`TLAT_A_EXT_D, 64'h0000_0080_0000_0000);
        wr(`TLAT_A_TAG, 64'h0000_0abc_de00_0005);
        wr(`TLAT_A_DIN_D, 64'h8000_1234_5678_0000);
        wr(`TLAT_A_TAG, 64'h0000_0000_4001_0005);
        wr(`TLAT_A_DIN_I, 64'hb000_0222_3333_0000);
        wr(`TLAT_A_TAG, 64'h0000_0000_7000_2005);
        wr(`TLAT_A_DIN_I, 64'h8000_0000_0aaa_0000);
        wr(`TLAT_A_DIN_I, 64'h9000_0000_0bbb_0000);
        // refill and micro hit on each side, then a multi hit on the instruction side and a miss on the data side
        foreach (rows[k])
        begin
            if (rows[k].d)
                u_dm.xlate(rows[k].va);
            else
                u_im.xlate(rows[k].va);
            g = rows[k].d ? u_dm.got : u_im.got;
            l = rows[k].d ? u_dm.lat : u_im.lat;
            `CHK("result", rows[k].r, g)
            `CHK("latency", rows[k].lat, l)
        end
        rd(`TLAT_A_STATUS, 64'h9);
        `CHK("irq", 1'b0, irq)
        wr(`TLAT_A_MASK, 64'h8);
        @(posedge sys_clk);
        `CHK("irq", 1'b1, irq)
        wr(`TLAT_A_STATUS, 64'h8);
        @(posedge sys_clk);
        `CHK("irq", 1'b0, irq)
        rd(`TLAT_A_STATUS, 64'h1);
        // every base select and split setting on a data-side miss
        for (int c = 0; c < 4; c++)
        begin
            v = 64'h0000_0000_0940_0000;
            wr(`TLAT_A_CTRL, {62'h0, c[1:0]});
            u_dm.xlate(v);
            b = c[0] ? 64'h0000_0080_0000_0000 : 64'h0000_0040_0000_0000;
            m = (64'h1 << (9 + c[1])) - 64'h1;
            rd(`TLAT_A_PTR_D, b | ((((v >> 13) ^ 64'h5) & m) << 4));
        end
        // instruction-side miss under legacy select takes its own extension base
        b = 64'h0000_00c0_0000_0000;
        wr(`TLAT_A_EXT_I, b);
        wr(`TLAT_A_CTRL, 64'h1);
        u_im.xlate(v);
        `CHK("result", 49'h0, u_im.got)
        rd(`TLAT_A_PTR_I, b | ((((v >> 13) ^ 64'h5) & 64'h1ff) << 4));
        resetn <= 1'b0;
        @(posedge sys_clk);
        `CHK("ready", 1'b0, d_ready)
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(`TLAT_A_CTRL, 64'h0);
        wrap_up();
    end
endmodule
